// [rtl/smb_defs.svh]
// Constants shared by the static memory bridge design files.
`ifndef SMB_DEFS_SVH
`define SMB_DEFS_SVH

`define SMB_AXI_AW 32
`define SMB_AXI_DW 64
`define SMB_AXI_SW 8
`define SMB_AXI_IW 4
`define SMB_AXI_LW 4
`define SMB_MEM_DW 16
`define SMB_MEM_AW 14
`define SMB_MEM_BW 2
`define SMB_HALVES 4
`define SMB_ROW_HI 14
`define SMB_ROW_LO 3
`define SMB_BURST_INCR 2'h1
`define SMB_BURST_WRAP 2'h2
`define SMB_RESP_OKAY 2'h0
`define SMB_BE_BOTH 2'h3
`define SMB_FIFO_DEPTH 8
`define SMB_FIFO_WIDTH 72

`endif

// [rtl/smb_pkg.sv]
// Types shared by the static memory bridge design files.
package smb_pkg;

	typedef enum logic [3:0] {
		SMB_ST_IDLE = 4'h0,
		SMB_ST_ACC_R = 4'h1,
		SMB_ST_RD_BEAT = 4'h2,
		SMB_ST_RD_RUN = 4'h3,
		SMB_ST_RD_OUT = 4'h4,
		SMB_ST_ACC_W = 4'h5,
		SMB_ST_WR_POP = 4'h6,
		SMB_ST_WR_RUN = 4'h7,
		SMB_ST_WR_RESP = 4'h8
	} smb_state_t;

endpackage

// [rtl/smb_fifo.sv]
// Buffer of write beats between the bus and the memory sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "smb_defs.svh"

module smb_fifo #(
	parameter int WIDTH = `SMB_FIFO_WIDTH,
	parameter int DEPTH = `SMB_FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr_reg, wr_ptr_next;
	logic [PW-1:0] rd_ptr_reg, rd_ptr_next;
	logic [PW:0] count_reg, count_next;
	logic in_ready_reg, in_ready_next;
	logic push, pop;

	assign in_ready = in_ready_reg;
	assign out_valid = (count_reg != '0);
	assign out_data = mem[rd_ptr_reg];

	always_comb begin
		push = in_valid && in_ready_reg;
		pop = out_valid && out_ready;
		wr_ptr_next = push ? PW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
		rd_ptr_next = pop ? PW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
		count_next = count_reg;
		if (push && !pop) begin
			count_next = (PW+1)'(count_reg + 1'b1);
		end else if (pop && !push) begin
			count_next = (PW+1)'(count_reg - 1'b1);
		end
		in_ready_next = (count_next != (PW+1)'(DEPTH));
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			in_ready_reg <= 1'b0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			count_reg <= count_next;
			in_ready_reg <= in_ready_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

endmodule
`default_nettype wire

// [rtl/smb_beat_calc.sv]
// Byte lanes of the current beat and the address of the next beat of a burst.
`timescale 1ns/1ps
`default_nettype none
`include "smb_defs.svh"

module smb_beat_calc (
	input wire logic [`SMB_AXI_AW-1:0] addr,
	input wire logic [2:0] size,
	input wire logic [1:0] burst,
	input wire logic [`SMB_AXI_LW-1:0] len,
	output logic [`SMB_AXI_SW-1:0] lane_mask,
	output logic [`SMB_AXI_AW-1:0] next_addr
);
	logic [3:0] bytes4, lo, hi;
	logic [`SMB_AXI_AW-1:0] bytes32, aligned, incr, wmask;

	always_comb begin
		bytes4 = 4'h1 << size;
		lo = {1'b0, addr[2:0]};
		hi = 4'({1'b0, addr[2:0] & ~3'(bytes4 - 4'h1)} + bytes4 - 4'h1);
		bytes32 = 32'h1 << size;
		aligned = addr & ~(bytes32 - 32'h1);
		incr = aligned + bytes32;
		wmask = (({28'h0, len} + 32'h1) << size) - 32'h1;
		if (burst == `SMB_BURST_WRAP) begin
			next_addr = (aligned & ~wmask) | (incr & wmask);
		end else begin
			next_addr = incr;
		end
	end

	for (genvar i = 0; i < `SMB_AXI_SW; i++) begin : g_lane
		assign lane_mask[i] = (4'(i) >= lo) && (4'(i) <= hi);
	end

endmodule
`default_nettype wire

// [rtl/smb_bridge.sv]
// Static memory bridge: AXI slave that runs 16-bit cycles on an on-chip SRAM.
// Overview of operation
// - Core logic is built to close timing at up to 200 MHz.
// - Read and write responses always report OKAY, never an error.
// - Bus side and core side are decoupled so commands and data pass safely.
// - AXI read and write data buses are 64 bits wide.
// - The memory data path is 16 bits wide.
// - The memory address is 14 bits wide.
// - Incrementing and wrapping bursts are handled; masters never issue fixed bursts.
// - Bursts of 1 to 16 beats are accepted.
// - Narrow and unaligned reads return only the addressed byte lanes; write byte lanes follow the write strobes.
// - Any IDs are accepted; transactions complete in acceptance order.
// - No low-power clock handshake channel exists.
// - Per-byte memory write enables follow the AXI write strobes.
// - Read data is captured only while the memory flags it valid.
// - While write hold is high the write command stays stable.
// - While read hold is high the read command stays stable.
// - Each transaction becomes a sequence of memory command cycles.
// - Read data returns with handshake, last marking and the transaction ID.
`timescale 1ns/1ps
`default_nettype none
`include "smb_defs.svh"

module smb_bridge
	import smb_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [`SMB_AXI_IW-1:0] awid,
	input wire logic [`SMB_AXI_AW-1:0] awaddr,
	input wire logic [`SMB_AXI_LW-1:0] awlen,
	input wire logic [2:0] awsize,
	input wire logic [1:0] awburst,
	input wire logic awvalid,
	output logic awready,
	input wire logic [`SMB_AXI_DW-1:0] wdata,
	input wire logic [`SMB_AXI_SW-1:0] wstrb,
	input wire logic wlast,
	input wire logic wvalid,
	output logic wready,
	output logic [`SMB_AXI_IW-1:0] bid,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [`SMB_AXI_IW-1:0] arid,
	input wire logic [`SMB_AXI_AW-1:0] araddr,
	input wire logic [`SMB_AXI_LW-1:0] arlen,
	input wire logic [2:0] arsize,
	input wire logic [1:0] arburst,
	input wire logic arvalid,
	output logic arready,
	output logic [`SMB_AXI_IW-1:0] rid,
	output logic [`SMB_AXI_DW-1:0] rdata,
	output logic [1:0] rresp,
	output logic rlast,
	output logic rvalid,
	input wire logic rready,
	output logic sram_cs,
	output logic sram_we,
	output logic [`SMB_MEM_AW-1:0] sram_addr,
	output logic [`SMB_MEM_DW-1:0] sram_wdata,
	output logic [`SMB_MEM_BW-1:0] sram_be,
	input wire logic [`SMB_MEM_DW-1:0] sram_rdata,
	input wire logic sram_rdata_valid,
	input wire logic sram_whold,
	input wire logic sram_rhold
);

	function automatic logic [3:0] half_mask(input logic [`SMB_AXI_SW-1:0] bm);
		logic [3:0] hm;
		hm = '0;
		for (int k = 0; k < `SMB_HALVES; k++) begin
			hm[k] = |bm[k*`SMB_MEM_BW +: `SMB_MEM_BW];
		end
		return hm;
	endfunction

	function automatic logic [1:0] lowest_half(input logic [3:0] hm);
		logic [1:0] k;
		k = '0;
		for (int i = `SMB_HALVES - 1; i >= 0; i--) begin
			if (hm[i]) begin
				k = 2'(i);
			end
		end
		return k;
	endfunction

	function automatic logic [`SMB_AXI_DW-1:0] lane_bits(input logic [`SMB_AXI_SW-1:0] bm);
		logic [`SMB_AXI_DW-1:0] m;
		m = '0;
		for (int k = 0; k < `SMB_AXI_SW; k++) begin
			m[k*(`SMB_AXI_DW / `SMB_AXI_SW) +: (`SMB_AXI_DW / `SMB_AXI_SW)] = {(`SMB_AXI_DW / `SMB_AXI_SW){bm[k]}};
		end
		return m;
	endfunction

	smb_state_t state_reg, state_next;
	logic [`SMB_AXI_IW-1:0] id_reg, id_next, bid_reg, bid_next, rid_reg, rid_next;
	logic [`SMB_AXI_AW-1:0] addr_reg, addr_next, next_addr;
	logic [2:0] size_reg, size_next;
	logic [1:0] burst_reg, burst_next, issue_k, fill_k;
	logic [`SMB_AXI_LW-1:0] len_reg, len_next, beat_reg, beat_next;
	logic [3:0] hmask_reg, hmask_next, fill_reg, fill_next;
	logic [`SMB_AXI_SW-1:0] bmask_reg, bmask_next, lane_mask;
	logic [`SMB_AXI_DW-1:0] wbeat_reg, wbeat_next, rbuf_reg, rbuf_next, rdata_reg, rdata_next;
	logic cmd_v_reg, cmd_v_next, cmd_we_reg, cmd_we_next;
	logic [`SMB_MEM_AW-1:0] cmd_addr_reg, cmd_addr_next;
	logic [`SMB_MEM_DW-1:0] cmd_wdata_reg, cmd_wdata_next;
	logic [`SMB_MEM_BW-1:0] cmd_be_reg, cmd_be_next;
	logic awready_reg, awready_next, arready_reg, arready_next;
	logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next, rlast_reg, rlast_next;
	logic cmd_taken, can_load, last_beat;
	logic fifo_out_valid, fifo_pop;
	logic [`SMB_FIFO_WIDTH-1:0] fifo_out_data;

	// Write beats are buffered so the bus side waits on memory cycles only once all 8 entries are full.
	smb_fifo #(
		.WIDTH(`SMB_FIFO_WIDTH),
		.DEPTH(`SMB_FIFO_DEPTH)
	) u_wfifo (
		.mclk(mclk),
		.reset_n(reset_n),
		.in_valid(wvalid),
		.in_ready(wready),
		.in_data({wstrb, wdata}),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);

	smb_beat_calc u_calc (
		.addr(addr_reg),
		.size(size_reg),
		.burst(burst_reg),
		.len(len_reg),
		.lane_mask(lane_mask),
		.next_addr(next_addr)
	);

	always_comb begin
		state_next = state_reg;
		id_next = id_reg;
		addr_next = addr_reg;
		size_next = size_reg;
		burst_next = burst_reg;
		len_next = len_reg;
		beat_next = beat_reg;
		hmask_next = hmask_reg;
		fill_next = fill_reg;
		bmask_next = bmask_reg;
		wbeat_next = wbeat_reg;
		rbuf_next = rbuf_reg;
		cmd_v_next = cmd_v_reg;
		cmd_we_next = cmd_we_reg;
		cmd_addr_next = cmd_addr_reg;
		cmd_wdata_next = cmd_wdata_reg;
		cmd_be_next = cmd_be_reg;
		awready_next = awready_reg;
		arready_next = arready_reg;
		bvalid_next = bvalid_reg;
		bid_next = bid_reg;
		rvalid_next = rvalid_reg;
		rlast_next = rlast_reg;
		rid_next = rid_reg;
		rdata_next = rdata_reg;
		fifo_pop = 1'b0;
		issue_k = lowest_half(hmask_reg);
		fill_k = lowest_half(fill_reg);
		last_beat = (beat_reg == len_reg);
		cmd_taken = cmd_v_reg && !(cmd_we_reg ? sram_whold : sram_rhold);
		can_load = !cmd_v_reg || cmd_taken;
		if (cmd_taken) begin
			cmd_v_next = 1'b0;
		end
		unique case (state_reg)
			SMB_ST_IDLE: begin
				// One transaction at a time keeps completion in acceptance order.
				if (arvalid) begin
					arready_next = 1'b1;
					state_next = SMB_ST_ACC_R;
				end else if (awvalid) begin
					awready_next = 1'b1;
					state_next = SMB_ST_ACC_W;
				end
			end
			SMB_ST_ACC_R: begin
				arready_next = 1'b0;
				id_next = arid;
				addr_next = araddr;
				size_next = arsize;
				burst_next = arburst;
				len_next = arlen;
				beat_next = '0;
				state_next = SMB_ST_RD_BEAT;
			end
			SMB_ST_RD_BEAT: begin
				hmask_next = half_mask(lane_mask);
				fill_next = half_mask(lane_mask);
				rbuf_next = '0;
				state_next = SMB_ST_RD_RUN;
			end
			SMB_ST_RD_RUN: begin
				if (can_load && (hmask_reg != '0)) begin
					cmd_v_next = 1'b1;
					cmd_we_next = 1'b0;
					cmd_addr_next = {addr_reg[`SMB_ROW_HI:`SMB_ROW_LO], issue_k};
					cmd_be_next = `SMB_BE_BOTH;
					hmask_next = hmask_reg & ~(4'h1 << issue_k);
				end
				if (sram_rdata_valid && (fill_reg != '0)) begin
					rbuf_next[fill_k*`SMB_MEM_DW +: `SMB_MEM_DW] = sram_rdata;
					fill_next = fill_reg & ~(4'h1 << fill_k);
				end
				if ((fill_reg == '0) && !cmd_v_reg) begin
					rvalid_next = 1'b1;
					rdata_next = rbuf_reg & lane_bits(lane_mask);
					rid_next = id_reg;
					rlast_next = last_beat;
					state_next = SMB_ST_RD_OUT;
				end
			end
			SMB_ST_RD_OUT: begin
				if (rready) begin
					rvalid_next = 1'b0;
					if (rlast_reg) begin
						state_next = SMB_ST_IDLE;
					end else begin
						addr_next = next_addr;
						beat_next = `SMB_AXI_LW'(beat_reg + 1'b1);
						state_next = SMB_ST_RD_BEAT;
					end
				end
			end
			SMB_ST_ACC_W: begin
				awready_next = 1'b0;
				id_next = awid;
				addr_next = awaddr;
				size_next = awsize;
				burst_next = awburst;
				len_next = awlen;
				beat_next = '0;
				state_next = SMB_ST_WR_POP;
			end
			SMB_ST_WR_POP: begin
				// Beats are taken in arrival order, relying on non-interleaved write data.
				fifo_pop = fifo_out_valid;
				if (fifo_out_valid) begin
					bmask_next = fifo_out_data[`SMB_FIFO_WIDTH-1 -: `SMB_AXI_SW];
					wbeat_next = fifo_out_data[`SMB_AXI_DW-1:0];
					hmask_next = half_mask(fifo_out_data[`SMB_FIFO_WIDTH-1 -: `SMB_AXI_SW]);
					state_next = SMB_ST_WR_RUN;
				end
			end
			SMB_ST_WR_RUN: begin
				if (can_load && (hmask_reg != '0)) begin
					cmd_v_next = 1'b1;
					cmd_we_next = 1'b1;
					cmd_addr_next = {addr_reg[`SMB_ROW_HI:`SMB_ROW_LO], issue_k};
					cmd_wdata_next = wbeat_reg[issue_k*`SMB_MEM_DW +: `SMB_MEM_DW];
					cmd_be_next = bmask_reg[issue_k*`SMB_MEM_BW +: `SMB_MEM_BW];
					hmask_next = hmask_reg & ~(4'h1 << issue_k);
				end else if (can_load && (hmask_reg == '0)) begin
					if (last_beat) begin
						bvalid_next = 1'b1;
						bid_next = id_reg;
						state_next = SMB_ST_WR_RESP;
					end else begin
						addr_next = next_addr;
						beat_next = `SMB_AXI_LW'(beat_reg + 1'b1);
						state_next = SMB_ST_WR_POP;
					end
				end
			end
			SMB_ST_WR_RESP: begin
				if (bready) begin
					bvalid_next = 1'b0;
					state_next = SMB_ST_IDLE;
				end
			end
			default: begin
				state_next = SMB_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= SMB_ST_IDLE;
			burst_reg <= `SMB_BURST_INCR;
			{id_reg, addr_reg, size_reg, len_reg, beat_reg, hmask_reg, fill_reg, bmask_reg} <= '0;
			{wbeat_reg, rbuf_reg, cmd_v_reg, cmd_we_reg, cmd_addr_reg, cmd_wdata_reg, cmd_be_reg} <= '0;
			{awready_reg, arready_reg, bvalid_reg, bid_reg, rvalid_reg, rlast_reg, rid_reg, rdata_reg} <= '0;
		end else begin
			state_reg <= state_next;
			{id_reg, addr_reg, size_reg, burst_reg} <= {id_next, addr_next, size_next, burst_next};
			{len_reg, beat_reg, hmask_reg, fill_reg} <= {len_next, beat_next, hmask_next, fill_next};
			{bmask_reg, wbeat_reg, rbuf_reg, cmd_v_reg} <= {bmask_next, wbeat_next, rbuf_next, cmd_v_next};
			{cmd_we_reg, cmd_addr_reg, cmd_wdata_reg, cmd_be_reg} <= {cmd_we_next, cmd_addr_next, cmd_wdata_next, cmd_be_next};
			{awready_reg, arready_reg, bvalid_reg, bid_reg} <= {awready_next, arready_next, bvalid_next, bid_next};
			{rvalid_reg, rlast_reg, rid_reg, rdata_reg} <= {rvalid_next, rlast_next, rid_next, rdata_next};
		end
	end

	// Every flop-to-flop path is a single state step, kept short for a fast core clock.
	assign awready = awready_reg;
	assign arready = arready_reg;
	assign bvalid = bvalid_reg;
	assign bid = bid_reg;
	assign bresp = `SMB_RESP_OKAY;
	assign rresp = `SMB_RESP_OKAY;
	assign rvalid = rvalid_reg;
	assign rlast = rlast_reg;
	assign rid = rid_reg;
	assign rdata = rdata_reg;
	// No clock low-power handshake is provided.
	assign sram_cs = cmd_v_reg;
	assign sram_we = cmd_we_reg;
	assign sram_addr = cmd_addr_reg;
	assign sram_wdata = cmd_wdata_reg;
	assign sram_be = cmd_be_reg;

endmodule
`default_nettype wire

// [test/smb_properties.sv]
// Concurrent checks on the static memory bridge ports.
`timescale 1ns/1ps
`default_nettype none

module smb_properties (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic awready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [3:0] bid,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [3:0] rid,
	input wire logic [63:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rlast,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic sram_cs,
	input wire logic sram_we,
	input wire logic [13:0] sram_addr,
	input wire logic [15:0] sram_wdata,
	input wire logic [1:0] sram_be,
	input wire logic sram_whold,
	input wire logic sram_rhold
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	sequence wr_held;
		sram_cs && sram_we && sram_whold;
	endsequence
	sequence rd_held;
		sram_cs && !sram_we && sram_rhold;
	endsequence
	sequence ar_take;
		arvalid && arready;
	endsequence
	sequence rd_cmd;
		sram_cs && !sram_we;
	endsequence
	a_resp_okay: assert property ((bvalid || rvalid) |-> bresp == 2'h0 && rresp == 2'h0)
		else $error("response code not okay");
	a_whold_stable: assert property (wr_held |=> sram_cs && sram_we && $stable({sram_addr, sram_wdata, sram_be}))
		else $error("write command moved under hold");
	a_rhold_stable: assert property (rd_held |=> rd_cmd and $stable(sram_addr))
		else $error("read command moved under hold");
	a_rdata_held: assert property (rvalid && !rready |=> rvalid && $stable({rid, rlast, rdata}))
		else $error("read beat dropped before taken");
	a_bvalid_held: assert property (bvalid && !bready |=> bvalid && $stable(bid))
		else $error("write response dropped before taken");
	a_read_be_full: assert property (rd_cmd |-> sram_be == 2'h3)
		else $error("read command without both bytes");
	a_write_be_live: assert property (sram_cs && sram_we |-> sram_be != 2'h0)
		else $error("write command with no byte enabled");
	a_one_txn: assert property ((bvalid || rvalid) |-> !awready && !arready)
		else $error("address taken during a transaction");
	a_ar_to_cmd: assert property (ar_take |-> ##[1:3] rd_cmd)
		else $error("no memory read after read address");
	a_ready_pulse: assert property (awready || arready |=> !awready && !arready)
		else $error("address ready longer than one cycle");
endmodule

bind smb_bridge smb_properties i_props (.*);

`default_nettype wire

// [test/smb_sram_model.sv]
// Behavioural on-chip memory with hold outputs and late read data.
`timescale 1ns/1ps
`default_nettype none

module smb_sram_model (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic sram_cs,
	input wire logic sram_we,
	input wire logic [13:0] sram_addr,
	input wire logic [15:0] sram_wdata,
	input wire logic [1:0] sram_be,
	output logic [15:0] sram_rdata,
	output logic sram_rdata_valid,
	output logic sram_whold,
	output logic sram_rhold
);
	logic [15:0] mem [0:16383];
	logic [15:0] pend [$];
	logic [31:0] r;
	integer seed = 32'h4691AFBD;
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sram_rdata <= 16'h0;
			sram_rdata_valid <= 1'b0;
			sram_whold <= 1'b0;
			sram_rhold <= 1'b0;
			pend.delete();
		end else begin
			r = $random(seed);
			if (pend.size() > 0 && r[0]) begin
				sram_rdata <= pend.pop_front();
				sram_rdata_valid <= 1'b1;
			end else begin
				sram_rdata <= ~sram_rdata;
				sram_rdata_valid <= 1'b0;
			end
			if (sram_cs && !sram_we && !sram_rhold)
				pend.push_back(mem[sram_addr]);
			if (sram_cs && sram_we && !sram_whold && sram_be[0])
				mem[sram_addr][7:0] <= sram_wdata[7:0];
			if (sram_cs && sram_we && !sram_whold && sram_be[1])
				mem[sram_addr][15:8] <= sram_wdata[15:8];
			sram_whold <= r[3:2] == 2'h0;
			sram_rhold <= r[5:4] == 2'h0;
		end
	end
endmodule

`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the static memory bridge.
`timescale 1ns/1ps
`default_nettype none
`include "smb_defs.svh"

module testbench;
	logic mclk = 1'b0;
	logic reset_n;
	logic [3:0] awid, arid, bid, rid, awlen, arlen;
	logic [31:0] awaddr, araddr;
	logic [2:0] awsize, arsize;
	logic [1:0] awburst, arburst, bresp, rresp, sram_be;
	logic awvalid, awready, wlast, wvalid, wready, bvalid, arvalid, arready, rlast, rvalid;
	logic rready = 1'b0;
	logic bready = 1'b0;
	logic [63:0] wdata, rdata;
	logic [7:0] wstrb;
	logic sram_cs, sram_we, sram_rdata_valid, sram_whold, sram_rhold;
	logic [13:0] sram_addr;
	logic [15:0] sram_wdata, sram_rdata;
	logic [7:0] shadow [0:32767];
	logic [68:0] rq [$];
	logic [3:0] bq [$];
	logic [68:0] note;
	int n_fail = 0;
	int compares = 0;
	integer seed = 32'h4691AFBD;

	always #4 mclk = ~mclk;

	smb_bridge i_smb_bridge (.*);
	smb_sram_model i_smb_sram_model (.*);

	task automatic results();
		if (n_fail == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [71:0] seen, input logic [71:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic hang();
		n_fail++;
		$display("Error wait expected handshake seen none");
		results();
	endtask

	task automatic wait_hi(ref logic s);
		int n;
		n = 0;
		while (s !== 1'b1) begin
			@(negedge mclk);
			n++;
			if (n > 400)
				hang();
		end
		@(negedge mclk);
	endtask

	function automatic logic [31:0] baddr(logic [31:0] a, logic [2:0] sz, logic [1:0] bt, logic [3:0] len, int i);
		logic [31:0] nb, al, tot, base;
		nb = 32'h1 << sz;
		al = a & ~(nb - 32'h1);
		tot = nb * (len + 32'h1);
		base = al & ~(tot - 32'h1);
		if (bt == `SMB_BURST_WRAP)
			return base + ((al - base + i * nb) % tot);
		return (i == 0) ? a : al + i * nb;
	endfunction

	task automatic addr_ph(input logic rd, input logic [3:0] id, input logic [31:0] a, input logic [3:0] len,
			input logic [2:0] sz, input logic [1:0] bt);
		if (rd) begin
			{arid, araddr, arlen, arsize, arburst, arvalid} = {id, a, len, sz, bt, 1'b1};
			wait_hi(arready);
			arvalid = 1'b0;
		end else begin
			{awid, awaddr, awlen, awsize, awburst, awvalid} = {id, a, len, sz, bt, 1'b1};
			wait_hi(awready);
			awvalid = 1'b0;
		end
		@(negedge mclk);
	endtask

	task automatic wbeats(input logic [31:0] a, input logic [3:0] len, input logic [1:0] bt, input logic full);
		logic [31:0] ba;
		for (int i = 0; i <= len; i++) begin
			ba = baddr(a, 3'h3, bt, len, i);
			wdata = {$random(seed), $random(seed)};
			wstrb = full ? 8'hFF : (i == 2 ? 8'h00 : 8'($random(seed)));
			wlast = (i == len);
			wvalid = 1'b1;
			for (int k = 0; k < 8; k++)
				if (wstrb[k])
					shadow[{ba[14:3], 3'(k)}] = wdata[8 * k +: 8];
			wait_hi(wready);
		end
		wvalid = 1'b0;
		@(negedge mclk);
	endtask

	task automatic wr(input logic [31:0] a, input logic [3:0] len, input logic [1:0] bt, input logic full,
			input logic pre);
		logic [3:0] id;
		id = 4'($random(seed));
		bq.push_back(id);
		if (pre) begin
			wbeats(a, len, bt, full);
			@(negedge mclk);
			chk("wready when full", 72'(wready), 72'h0);
			addr_ph(1'b0, id, a, len, 3'h3, bt);
		end else begin
			fork
				addr_ph(1'b0, id, a, len, 3'h3, bt);
				wbeats(a, len, bt, full);
			join
		end
	endtask

	task automatic rd(input logic [31:0] a, input logic [3:0] len, input logic [2:0] sz, input logic [1:0] bt);
		logic [3:0] id;
		logic [31:0] ba;
		logic [63:0] d;
		int lo, hi;
		id = 4'($random(seed));
		for (int i = 0; i <= len; i++) begin
			ba = baddr(a, sz, bt, len, i);
			lo = ba[2:0];
			hi = ((lo >> sz) << sz) + (1 << sz);
			d = 64'h0;
			for (int k = lo; k < hi; k++)
				d[8 * k +: 8] = shadow[{ba[14:3], 3'(k)}];
			rq.push_back({id, i == len, d});
		end
		addr_ph(1'b1, id, a, len, sz, bt);
	endtask

	always @(negedge mclk) begin
		rready <= 1'($random(seed));
		bready <= 1'($random(seed));
	end

	always @(posedge mclk) begin
		if (reset_n && rvalid && rready) begin
			note = rq.size() > 0 ? rq.pop_front() : 69'h0;
			chk("read beat", 72'({rid, rlast, rdata}), 72'(note));
			chk("rresp", 72'(rresp), 72'h0);
		end
		if (reset_n && bvalid && bready) begin
			chk("bid", 72'(bid), 72'(bq.size() > 0 ? bq.pop_front() : 4'h0));
			chk("bresp", 72'(bresp), 72'h0);
		end
	end

	initial begin
		logic [31:0] a;
		reset_n = 1'b0;
		{awvalid, wvalid, arvalid, wlast} = 4'h0;
		{awid, awaddr, awlen, awsize, awburst, wdata, wstrb} = '0;
		{arid, araddr, arlen, arsize, arburst} = '0;
		repeat (2) @(negedge mclk);
		reset_n = 1'b1;
		@(negedge mclk);
		wr(32'h0, 4'hF, `SMB_BURST_INCR, 1'b1, 1'b0);
		wr(32'h40, 4'h7, `SMB_BURST_INCR, 1'b0, 1'b1);
		wr(32'h18, 4'h3, `SMB_BURST_WRAP, 1'b0, 1'b0);
		rd(32'h0, 4'hF, 3'h3, `SMB_BURST_INCR);
		rd(32'h28, 4'h7, 3'h3, `SMB_BURST_WRAP);
		rd(32'h42, 4'h2, 3'h1, `SMB_BURST_INCR);
		rd(32'h43, 4'h1, 3'h3, `SMB_BURST_INCR);
		rd(32'h17, 4'h0, 3'h0, `SMB_BURST_INCR);
		rd(32'h1C, 4'h3, 3'h2, `SMB_BURST_WRAP);
		repeat (4) begin
			a = 32'($random(seed)) & 32'h38;
			wr(a, 4'h7, `SMB_BURST_INCR, 1'b0, 1'b0);
			rd(a, 4'h7, 3'h3, `SMB_BURST_INCR);
		end
		repeat (3000) begin
			if (rq.size() == 0 && bq.size() == 0)
				break;
			@(negedge mclk);
		end
		if (rq.size() + bq.size() > 0)
			hang();
		results();
	end
endmodule

`default_nettype wire
